// *** rtl/dccr_pkg.sv ***
// constants shared by the register bank and its watchdog
// assumes a single core clock; registers reached over apb
package dccr_pkg;

  // ==========================================================
  // clock
  localparam int unsigned CLK_HZ = 10_000_000;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_SOFT_RESET = 6'h01;
  localparam logic [5:0] IDX_RESET_CFG = 6'h02;
  localparam logic [5:0] IDX_CHAN_SEL = 6'h03;
  localparam logic [5:0] IDX_OUT_CFG = 6'h04;
  localparam logic [5:0] IDX_DAC_DATA = 6'h05;
  localparam logic [5:0] IDX_STATUS = 6'h0b;
  localparam logic [5:0] IDX_MASK = 6'h0c;
  localparam logic [5:0] IDX_WD_RESTART = 6'h10;

  // ==========================================================
  // reset_and_clear_config fields
  localparam int RC_TOGGLE = 0;
  localparam int RC_POC = 1;
  localparam int RC_CLEAR = 2;
  localparam int RC_TRN = 3;
  localparam int RC_REF = 4;
  localparam int RC_CLEAR_ENABLE = 9;
  localparam int RC_USER_LO = 10;
  localparam logic [15:0] RC_WMASK = 16'h1e1f;

  // channel_select_and_safety fields
  localparam int CS_WEN = 0;
  localparam int CS_WPD_LO = 1;
  localparam int CS_CRC = 3;
  localparam int CS_SDO_DIS = 4;
  localparam int CS_CHAN = 5;
  localparam int CS_CLSEL = 9;
  localparam logic [15:0] CS_WMASK = 16'h023f;

  // output_configuration fields
  localparam int OC_RANGE_LO = 0;
  localparam int OC_SLEW_EN = 4;
  localparam int OC_STEP_LO = 5;
  localparam int OC_RATE_LO = 8;
  localparam int OC_OUT_EN = 12;
  localparam int OC_MODEM = 13;
  localparam int OC_SHORT_CIRCUIT_LIMIT_LO = 14;

  // status and mask fields
  localparam int ST_TOGGLE = 6;
  localparam int ST_WDT = 11;
  localparam int ST_CLR_DONE = 12;
  localparam logic [15:0] ST_W1C = 16'h1800;

  // ==========================================================
  // reset values and clear levels
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] ZERO_SCALE = 16'h0000;
  localparam logic [15:0] MID_SCALE = 16'h8000;

  // ==========================================================
  // watchdog periods
  localparam int unsigned WD_PERIOD_US0 = 10_000;
  localparam int unsigned WD_PERIOD_US1 = 51_000;
  localparam int unsigned WD_PERIOD_US2 = 102_000;
  localparam int unsigned WD_PERIOD_US3 = 204_000;
  localparam int unsigned WD_CYC0 = WD_PERIOD_US0 * (CLK_HZ / 1_000_000);
  localparam int unsigned WD_CYC1 = WD_PERIOD_US1 * (CLK_HZ / 1_000_000);
  localparam int unsigned WD_CYC2 = WD_PERIOD_US2 * (CLK_HZ / 1_000_000);
  localparam int unsigned WD_CYC3 = WD_PERIOD_US3 * (CLK_HZ / 1_000_000);

  // ==========================================================
  // slew update rates in hz and derived reload counts
  localparam int unsigned SLEW_HZ [16] = '{
    258065, 200000, 153845, 131145, 115940, 69565, 37560, 25805,
    20150, 16030, 10295, 8280, 6900, 5530, 4240, 3300};
  localparam logic [11:0] SLEW_RELOAD [16] = '{
    12'(CLK_HZ / SLEW_HZ[0] - 1), 12'(CLK_HZ / SLEW_HZ[1] - 1),
    12'(CLK_HZ / SLEW_HZ[2] - 1), 12'(CLK_HZ / SLEW_HZ[3] - 1),
    12'(CLK_HZ / SLEW_HZ[4] - 1), 12'(CLK_HZ / SLEW_HZ[5] - 1),
    12'(CLK_HZ / SLEW_HZ[6] - 1), 12'(CLK_HZ / SLEW_HZ[7] - 1),
    12'(CLK_HZ / SLEW_HZ[8] - 1), 12'(CLK_HZ / SLEW_HZ[9] - 1),
    12'(CLK_HZ / SLEW_HZ[10] - 1), 12'(CLK_HZ / SLEW_HZ[11] - 1),
    12'(CLK_HZ / SLEW_HZ[12] - 1), 12'(CLK_HZ / SLEW_HZ[13] - 1),
    12'(CLK_HZ / SLEW_HZ[14] - 1), 12'(CLK_HZ / SLEW_HZ[15] - 1)};

endpackage

// *** rtl/dccr_watchdog.sv ***
// watchdog timer of the register bank
// assumes restart and enable come from logic on the same clock
`timescale 1ns/1ps
module dccr_watchdog #(
  parameter int unsigned P_CYC0 = dccr_pkg::WD_CYC0,
  parameter int unsigned P_CYC1 = dccr_pkg::WD_CYC1,
  parameter int unsigned P_CYC2 = dccr_pkg::WD_CYC2,
  parameter int unsigned P_CYC3 = dccr_pkg::WD_CYC3
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_enable,
  input wire logic [1:0] i_period,
  input wire logic i_restart,
  output logic o_timeout
);

  typedef struct packed {
    logic [21:0] cnt;
    logic timeout;
  } dccr_wd_s;

  dccr_wd_s wd_reg;
  dccr_wd_s wd_next;
  logic [21:0] limit;

  // ==========================================================
  // period select
  always_comb
  begin
    case (i_period)
      2'b00: limit = 22'(P_CYC0 - 1);
      2'b01: limit = 22'(P_CYC1 - 1);
      2'b10: limit = 22'(P_CYC2 - 1);
      default: limit = 22'(P_CYC3 - 1);
    endcase
  end

  // ==========================================================
  // counter
  always_comb
  begin
    wd_next = wd_reg;
    wd_next.timeout = 1'b0;
    if (!i_enable || i_restart)
    begin
      wd_next.cnt = '0;
    end
    else if (wd_reg.cnt >= limit)
    begin
      wd_next.cnt = '0;
      wd_next.timeout = 1'b1;
    end
    else
    begin
      wd_next.cnt = 22'(wd_reg.cnt + 22'h000001);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      wd_reg <= '0;
    else
      wd_reg <= wd_next;
  end

  assign o_timeout = wd_reg.timeout;

  // ==========================================================
  // checks
  property p_wd_disabled;
    @(posedge i_core_clk) disable iff (!i_resetn)
      !i_enable |=> (wd_reg.cnt == '0) && !o_timeout;
  endproperty
  a_wd_disabled: assert property (p_wd_disabled)
    else $error("watchdog runs while disabled");

  property p_wd_restart;
    @(posedge i_core_clk) disable iff (!i_resetn)
      i_restart |=> wd_reg.cnt == '0 ##1 !o_timeout;
  endproperty
  a_wd_restart: assert property (p_wd_restart)
    else $error("restart write did not restart the count");

  property p_wd_expire;
    @(posedge i_core_clk) disable iff (!i_resetn)
      i_enable && !i_restart && wd_reg.cnt == limit |=> o_timeout;
  endproperty
  a_wd_expire: assert property (p_wd_expire)
    else $error("watchdog did not expire at the period");

  property p_wd_cause;
    @(posedge i_core_clk) disable iff (!i_resetn)
      o_timeout |-> $past(i_enable) && !$past(i_restart)
        && $past(wd_reg.cnt) >= $past(limit);
  endproperty
  a_wd_cause: assert property (p_wd_cause)
    else $error("timeout without expiry");

endmodule

// *** rtl/dccr_top.sv ***
// control and configuration register bank of a single channel dac
// assumes an apb master on i_core_clk; clear pin is asynchronous
//
// Function
// - status toggle echo bit follows the user toggle bit written.
// - clear command is active high, forces clear level, then self-clears.
// - pin and software clears act only while clear enable is one.
// - clear loads zero scale if clear select is zero, else mid scale.
// - after reset vout follows power-off condition: pulldown or high-z; iout stays high-z.
// - internal reference enabled only while reference enable bit is one.
// - transparent mode follows the transparent mode bit.
// - three user bits at 12, 11, 10, host written, reset zero.
// - serial out disable stops daisy chain and floats serial out.
// - checksum enable turns on frame checking; host then sends checksum.
// - two-bit watchdog period picks 10, 51, 102 or 204 ms.
// - watchdog runs only while watchdog enable bit is set.
// - channel select word at 0x03 decoded into its fields, reset zero.
// - output configuration word at 0x04 decoded into its fields.
// - dac output driven only while output enable set; off after reset.
// - each write to restart register restarts the watchdog count.
// - software reset restores all defaults except power-off condition.
`timescale 1ns/1ps
module dccr_top #(
  parameter int unsigned P_WD_CYC0 = dccr_pkg::WD_CYC0,
  parameter int unsigned P_WD_CYC1 = dccr_pkg::WD_CYC1,
  parameter int unsigned P_WD_CYC2 = dccr_pkg::WD_CYC2,
  parameter int unsigned P_WD_CYC3 = dccr_pkg::WD_CYC3
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_clear_pin,
  output logic o_irq,
  output logic [15:0] o_dac_code,
  output logic o_output_enable,
  output logic o_iout_hiz,
  output logic o_vout_pulldown,
  output logic o_power_off_condition,
  output logic o_ref_enable,
  output logic o_transparent_mode,
  output logic [2:0] o_user_bits,
  output logic o_channel_one_select,
  output logic o_sdo_oe,
  output logic o_checksum_enable,
  output logic [1:0] o_short_circuit_limit,
  output logic o_modem_enable,
  output logic [3:0] o_range
);

  typedef struct packed {
    logic sync_a;
    logic sync_b;
    logic rst_pend;
    logic [15:0] rcfg;
    logic [15:0] csel;
    logic [15:0] ocfg;
    logic [15:0] ddata;
    logic [15:0] code;
    logic sts_wdt;
    logic sts_clr;
    logic [15:0] mask;
    logic [11:0] slew_cnt;
    logic [31:0] prdata;
  } dccr_state_s;

  dccr_state_s st_reg;
  dccr_state_s st_next;

  logic [5:0] idx;
  logic setup;
  logic access;
  logic mapped;
  logic wr;
  logic clr_do;
  logic [15:0] clr_lvl;
  logic [15:0] rd_word;
  logic [15:0] w1c;
  logic wd_timeout;
  logic wd_restart;

  // ==========================================================
  // helpers
  function automatic logic is_mapped(input logic [7:0] addr);
    logic [5:0] i;
    i = addr[7:2];
    is_mapped = (addr[1:0] == 2'b00) &&
      (i == dccr_pkg::IDX_SOFT_RESET || i == dccr_pkg::IDX_RESET_CFG ||
       i == dccr_pkg::IDX_CHAN_SEL || i == dccr_pkg::IDX_OUT_CFG ||
       i == dccr_pkg::IDX_DAC_DATA || i == dccr_pkg::IDX_STATUS ||
       i == dccr_pkg::IDX_MASK || i == dccr_pkg::IDX_WD_RESTART);
  endfunction

  function automatic logic [15:0] step_toward(input logic [15:0] cur,
    input logic [15:0] tgt, input logic [2:0] step);
    logic [15:0] inc;
    logic [15:0] d;
    inc = 16'h0001 << step;
    if (tgt > cur)
    begin
      d = 16'(tgt - cur);
      step_toward = (d > inc) ? 16'(cur + inc) : tgt;
    end
    else
    begin
      d = 16'(cur - tgt);
      step_toward = (d > inc) ? 16'(cur - inc) : tgt;
    end
  endfunction

  // ==========================================================
  // apb decode
  assign idx = i_paddr[7:2];
  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  assign mapped = is_mapped(i_paddr);
  assign wr = access && i_pwrite && mapped;
  assign wd_restart = wr && (idx == dccr_pkg::IDX_WD_RESTART);
  assign o_pready = 1'b1;
  assign o_pslverr = access && !mapped;
  assign o_prdata = st_reg.prdata;

  // ==========================================================
  // clear control
  assign clr_do = st_reg.rcfg[dccr_pkg::RC_CLEAR_ENABLE] &&
    (st_reg.rcfg[dccr_pkg::RC_CLEAR] || st_reg.sync_b);
  assign clr_lvl = st_reg.csel[dccr_pkg::CS_CLSEL] ?
    dccr_pkg::MID_SCALE : dccr_pkg::ZERO_SCALE;
  assign w1c = (wr && idx == dccr_pkg::IDX_STATUS) ?
    (i_pwdata[15:0] & dccr_pkg::ST_W1C) : 16'h0000;

  // ==========================================================
  // read mux
  always_comb
  begin
    rd_word = 16'h0000;
    case (idx)
      dccr_pkg::IDX_SOFT_RESET: rd_word = {15'h0000, st_reg.rst_pend};
      dccr_pkg::IDX_RESET_CFG: rd_word = st_reg.rcfg;
      dccr_pkg::IDX_CHAN_SEL: rd_word = st_reg.csel;
      dccr_pkg::IDX_OUT_CFG: rd_word = st_reg.ocfg;
      dccr_pkg::IDX_DAC_DATA: rd_word = st_reg.ddata;
      dccr_pkg::IDX_STATUS:
      begin
        rd_word[dccr_pkg::ST_TOGGLE] =
          st_reg.rcfg[dccr_pkg::RC_TOGGLE];
        rd_word[dccr_pkg::ST_WDT] = st_reg.sts_wdt;
        rd_word[dccr_pkg::ST_CLR_DONE] = st_reg.sts_clr;
      end
      dccr_pkg::IDX_MASK: rd_word = st_reg.mask;
      default: rd_word = 16'h0000;
    endcase
    if (!mapped)
      rd_word = 16'h0000;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    st_next = st_reg;
    st_next.sync_a = i_clear_pin;
    st_next.sync_b = st_reg.sync_a;
    // slew engine
    if (!st_reg.ocfg[dccr_pkg::OC_SLEW_EN])
    begin
      st_next.code = st_reg.ddata;
      st_next.slew_cnt = 12'h000;
    end
    else if (st_reg.slew_cnt != 12'h000)
    begin
      st_next.slew_cnt = 12'(st_reg.slew_cnt - 12'h001);
    end
    else
    begin
      st_next.slew_cnt = dccr_pkg::SLEW_RELOAD[
        st_reg.ocfg[dccr_pkg::OC_RATE_LO +: 4]];
      st_next.code = step_toward(st_reg.code, st_reg.ddata,
        st_reg.ocfg[dccr_pkg::OC_STEP_LO +: 3]);
    end
    // clear forces data and code at once
    if (clr_do)
    begin
      st_next.ddata = clr_lvl;
      st_next.code = clr_lvl;
    end
    st_next.rcfg[dccr_pkg::RC_CLEAR] = 1'b0;
    // register writes
    if (wr)
    begin
      case (idx)
        dccr_pkg::IDX_SOFT_RESET: st_next.rst_pend = i_pwdata[0];
        dccr_pkg::IDX_RESET_CFG:
          st_next.rcfg = i_pwdata[15:0] & dccr_pkg::RC_WMASK;
        dccr_pkg::IDX_CHAN_SEL:
          st_next.csel = i_pwdata[15:0] & dccr_pkg::CS_WMASK;
        dccr_pkg::IDX_OUT_CFG: st_next.ocfg = i_pwdata[15:0];
        dccr_pkg::IDX_DAC_DATA: st_next.ddata = i_pwdata[15:0];
        dccr_pkg::IDX_MASK:
          st_next.mask = i_pwdata[15:0] & dccr_pkg::ST_W1C;
        default: st_next.rst_pend = st_reg.rst_pend;
      endcase
    end
    // sticky flags, set wins over clear
    st_next.sts_wdt = (st_reg.sts_wdt && !w1c[dccr_pkg::ST_WDT]) ||
      wd_timeout;
    st_next.sts_clr = (st_reg.sts_clr && !w1c[dccr_pkg::ST_CLR_DONE]) ||
      clr_do;
    // read data captured in setup
    if (setup && !i_pwrite)
      st_next.prdata = {16'h0000, rd_word};
    // software reset keeps power-off condition
    if (st_reg.rst_pend)
    begin
      st_next.rcfg = dccr_pkg::REG_RESET;
      st_next.rcfg[dccr_pkg::RC_POC] = st_reg.rcfg[dccr_pkg::RC_POC];
      st_next.csel = dccr_pkg::REG_RESET;
      st_next.ocfg = dccr_pkg::REG_RESET;
      st_next.ddata = dccr_pkg::REG_RESET;
      st_next.code = dccr_pkg::REG_RESET;
      st_next.mask = dccr_pkg::REG_RESET;
      st_next.sts_wdt = 1'b0;
      st_next.sts_clr = 1'b0;
      st_next.slew_cnt = 12'h000;
      st_next.rst_pend = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // ==========================================================
  // watchdog
  dccr_watchdog #(
    .P_CYC0(P_WD_CYC0),
    .P_CYC1(P_WD_CYC1),
    .P_CYC2(P_WD_CYC2),
    .P_CYC3(P_WD_CYC3)
  ) u_wd (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_enable(st_reg.csel[dccr_pkg::CS_WEN]),
    .i_period(st_reg.csel[dccr_pkg::CS_WPD_LO +: 2]),
    .i_restart(wd_restart),
    .o_timeout(wd_timeout)
  );

  // ==========================================================
  // outputs
  assign o_irq = (st_reg.sts_wdt && !st_reg.mask[dccr_pkg::ST_WDT]) ||
    (st_reg.sts_clr && !st_reg.mask[dccr_pkg::ST_CLR_DONE]);
  assign o_dac_code = st_reg.code;
  assign o_output_enable = st_reg.ocfg[dccr_pkg::OC_OUT_EN];
  assign o_iout_hiz = !st_reg.ocfg[dccr_pkg::OC_OUT_EN];
  assign o_vout_pulldown = !st_reg.ocfg[dccr_pkg::OC_OUT_EN] &&
    !st_reg.rcfg[dccr_pkg::RC_POC];
  assign o_power_off_condition = st_reg.rcfg[dccr_pkg::RC_POC];
  assign o_ref_enable = st_reg.rcfg[dccr_pkg::RC_REF];
  assign o_transparent_mode = st_reg.rcfg[dccr_pkg::RC_TRN];
  assign o_user_bits = st_reg.rcfg[dccr_pkg::RC_USER_LO +: 3];
  assign o_channel_one_select = st_reg.csel[dccr_pkg::CS_CHAN];
  assign o_sdo_oe = !st_reg.csel[dccr_pkg::CS_SDO_DIS];
  assign o_checksum_enable = st_reg.csel[dccr_pkg::CS_CRC];
  assign o_short_circuit_limit =
    st_reg.ocfg[dccr_pkg::OC_SHORT_CIRCUIT_LIMIT_LO +: 2];
  assign o_modem_enable = st_reg.ocfg[dccr_pkg::OC_MODEM];
  assign o_range = st_reg.ocfg[dccr_pkg::OC_RANGE_LO +: 4];

  // ==========================================================
  // checks
  property p_toggle_echo;
    @(posedge i_core_clk) disable iff (!i_resetn)
      wr && idx == dccr_pkg::IDX_RESET_CFG && !st_reg.rst_pend
      |=> st_reg.rcfg[dccr_pkg::RC_TOGGLE] == $past(i_pwdata[0]);
  endproperty
  a_toggle_echo: assert property (p_toggle_echo)
    else $error("toggle echo does not follow written bit");

  property p_clear_self;
    @(posedge i_core_clk) disable iff (!i_resetn)
      st_reg.rcfg[dccr_pkg::RC_CLEAR] && !wr
      |=> !st_reg.rcfg[dccr_pkg::RC_CLEAR];
  endproperty
  a_clear_self: assert property (p_clear_self)
    else $error("clear command bit did not self clear");

  property p_clear_blocked;
    @(posedge i_core_clk) disable iff (!i_resetn)
      !st_reg.rcfg[dccr_pkg::RC_CLEAR_ENABLE] && !wr && !st_reg.rst_pend
      |=> st_reg.ddata == $past(st_reg.ddata) &&
        (!st_reg.sts_clr || $past(st_reg.sts_clr));
  endproperty
  a_clear_blocked: assert property (p_clear_blocked)
    else $error("clear acted while clear disabled");

  property p_clear_level;
    @(posedge i_core_clk) disable iff (!i_resetn)
      clr_do && !wr && !st_reg.rst_pend
      |=> st_reg.code == (st_reg.csel[dccr_pkg::CS_CLSEL] ?
        dccr_pkg::MID_SCALE : dccr_pkg::ZERO_SCALE)
        && st_reg.ddata == st_reg.code;
  endproperty
  a_clear_level: assert property (p_clear_level)
    else $error("clear loaded the wrong level");

  property p_poc_outputs;
    @(posedge i_core_clk) disable iff (!i_resetn)
      !o_output_enable |-> o_iout_hiz &&
        (o_vout_pulldown == !o_power_off_condition);
  endproperty
  a_poc_outputs: assert property (p_poc_outputs)
    else $error("disabled outputs ignore power-off condition");

  property p_sdo_float;
    @(posedge i_core_clk) disable iff (!i_resetn)
      wr && idx == dccr_pkg::IDX_CHAN_SEL && i_pwdata[4] &&
      !st_reg.rst_pend |=> !o_sdo_oe;
  endproperty
  a_sdo_float: assert property (p_sdo_float)
    else $error("serial out still driven when disabled");

  property p_slew_off;
    @(posedge i_core_clk) disable iff (!i_resetn)
      !st_reg.ocfg[dccr_pkg::OC_SLEW_EN] && !clr_do && !st_reg.rst_pend
      |=> o_dac_code == $past(st_reg.ddata);
  endproperty
  a_slew_off: assert property (p_slew_off)
    else $error("code does not follow data without slew");

  property p_slew_step;
    @(posedge i_core_clk) disable iff (!i_resetn)
      st_reg.ocfg[dccr_pkg::OC_SLEW_EN] && !clr_do && !st_reg.rst_pend
      && st_reg.slew_cnt != 12'h000 |=> $stable(o_dac_code);
  endproperty
  a_slew_step: assert property (p_slew_step)
    else $error("code moved between slew ticks");

  property p_soft_reset;
    @(posedge i_core_clk) disable iff (!i_resetn)
      st_reg.rst_pend |=> st_reg.ocfg == dccr_pkg::REG_RESET &&
        st_reg.csel == dccr_pkg::REG_RESET && !st_reg.rst_pend &&
        o_power_off_condition == $past(o_power_off_condition);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("software reset did not restore defaults");

  property p_wdt_flag;
    @(posedge i_core_clk) disable iff (!i_resetn)
      wd_timeout && !st_reg.rst_pend |=> st_reg.sts_wdt;
  endproperty
  a_wdt_flag: assert property (p_wdt_flag)
    else $error("watchdog expiry not flagged");

endmodule

// *** tb/dccr_host.sv ***
// host controller model: apb master issuing register transfers
// assumes zero or more wait states, pready sampled at rising edges
`timescale 1ns/1ps
module dccr_host (
  input wire logic i_core_clk,
  input wire logic i_pready,
  input wire logic [31:0] i_prdata,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata
);
  // ==========================================================
  // one transfer, held until pready
  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge i_core_clk);
    o_psel <= 1'b1;
    o_pwrite <= wr;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_core_clk);
    o_penable <= 1'b1;
    do @(posedge i_core_clk); while (i_pready !== 1'b1);
    rd = i_prdata;
    err = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
  endtask
endmodule

// *** tb/tb_dccr_top.sv ***
// self-checking bench of the register bank
// assumes the host model drives the apb port, 10 mhz clock
`timescale 1ns/1ps
`define CHK(n, x, g) begin check_count++; if ((g) !== (x)) begin \
  n_errors++; $display("mismatch %s exp %h got %h", n, x, g); end end
module tb_dccr_top;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_clear_pin = 1'b0;
  logic i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, v;
  logic [15:0] o_dac_code;
  logic o_oe, o_hiz, o_pd, o_poc, o_ref, o_trn, o_cha, o_sdo, o_crc, o_mdm;
  logic [2:0] o_user;
  logic [1:0] o_scl;
  logic [3:0] o_rng;
  logic e;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  localparam int WD[4] = '{20, 40, 60, 80};
  // ==========================================================
  // clock, design, host
  always #50 i_core_clk = ~i_core_clk;
  dccr_top #(.P_WD_CYC0(WD[0]), .P_WD_CYC1(WD[1]), .P_WD_CYC2(WD[2]),
    .P_WD_CYC3(WD[3])) uut (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_clear_pin(i_clear_pin),
    .o_irq(o_irq), .o_dac_code(o_dac_code), .o_output_enable(o_oe),
    .o_iout_hiz(o_hiz), .o_vout_pulldown(o_pd),
    .o_power_off_condition(o_poc), .o_ref_enable(o_ref),
    .o_transparent_mode(o_trn), .o_user_bits(o_user),
    .o_channel_one_select(o_cha), .o_sdo_oe(o_sdo),
    .o_checksum_enable(o_crc), .o_short_circuit_limit(o_scl),
    .o_modem_enable(o_mdm), .o_range(o_rng));
  dccr_host host (.i_core_clk(i_core_clk), .i_pready(o_pready),
    .i_prdata(o_prdata), .i_pslverr(o_pslverr), .o_psel(i_psel),
    .o_penable(i_penable), .o_pwrite(i_pwrite), .o_paddr(i_paddr),
    .o_pwdata(i_pwdata));
  // ==========================================================
  // tasks
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.xfer(1'b1, a, {16'h0000, d}, v, e);
    @(negedge i_core_clk);
  endtask
  task automatic rdc(input string n, input logic [7:0] a,
    input logic [15:0] x);
    host.xfer(1'b0, a, 32'h0, v, e);
    `CHK(n, {16'h0000, x}, v)
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      give_verdict;
    end
  end
  // ==========================================================
  // tests
  initial
  begin
    idle(2);
    i_resetn <= 1'b1;
    `CHK("pins", 5'b11100, {o_hiz, o_pd, o_sdo, o_oe, o_ref})
    rdc("rcfg", 8'h08, 16'h0000);
    rdc("csel", 8'h0c, 16'h0000);
    rdc("ocfg", 8'h10, 16'h0000);
    $display("test reset done");
    wr(8'h08, 16'h1c19);
    idle(2);
    `CHK("cfg", 5'b11111, {o_user, o_ref, o_trn})
    rdc("tgl", 8'h2c, 16'h0040);
    wr(8'h08, 16'h0000);
    idle(2);
    `CHK("cfg", 5'b00000, {o_user, o_ref, o_trn})
    rdc("tgl", 8'h2c, 16'h0000);
    wr(8'h0c, 16'h023e);
    idle(2);
    `CHK("csel", 3'b011, {o_sdo, o_crc, o_cha})
    rdc("csel", 8'h0c, 16'h023e);
    wr(8'h10, 16'hf00f);
    idle(2);
    `CHK("ocfg", 10'h3fc, {o_scl, o_mdm, o_oe, o_rng, o_hiz, o_pd})
    $display("test fields done");
    wr(8'h14, 16'h1234);
    wr(8'h08, 16'h0004);
    idle(3);
    `CHK("noclr", 16'h1234, o_dac_code)
    rdc("clrbit", 8'h08, 16'h0000);
    wr(8'h08, 16'h0204);
    idle(3);
    `CHK("mid", 16'h8000, o_dac_code)
    rdc("clrbit", 8'h08, 16'h0200);
    wr(8'h0c, 16'h0000);
    wr(8'h14, 16'h1234);
    idle(1);
    i_clear_pin <= 1'b1;
    idle(5);
    i_clear_pin <= 1'b0;
    idle(2);
    `CHK("zero", 16'h0000, o_dac_code)
    `CHK("irq", 1'b1, o_irq)
    wr(8'h2c, 16'h1800);
    `CHK("irq", 1'b0, o_irq)
    $display("test clear done");
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h0c, 16'(1 + 2 * p));
      idle(WD[p] - 10);
      rdc("wdt", 8'h2c, 16'h0000);
      idle(10);
      rdc("wdt", 8'h2c, 16'h0800);
      wr(8'h0c, 16'h0000);
      wr(8'h2c, 16'h0800);
    end
    wr(8'h0c, 16'h0003);
    repeat (5)
    begin
      idle(20);
      wr(8'h40, 16'h0001);
    end
    rdc("wdr", 8'h2c, 16'h0000);
    idle(45);
    `CHK("irq", 1'b1, o_irq)
    wr(8'h30, 16'h0800);
    `CHK("irqm", 1'b0, o_irq)
    wr(8'h0c, 16'h0000);
    wr(8'h2c, 16'h0800);
    wr(8'h30, 16'h1800);
    $display("test watchdog done");
    wr(8'h08, 16'h0003);
    wr(8'h04, 16'h0001);
    idle(3);
    rdc("srst", 8'h08, 16'h0002);
    rdc("srst", 8'h30, 16'h0000);
    `CHK("poc", 3'b101, {o_hiz, o_pd, o_poc})
    host.xfer(1'b0, 8'h3c, 32'h0, v, e);
    `CHK("unmap", 33'h100000000, {e, v})
    `CHK("rdy", 1'b1, o_pready)
    wr(8'h10, 16'h10f0);
    wr(8'h14, 16'h0400);
    idle(45);
    `CHK("slew", 1'b1, o_dac_code inside {16'h0080, 16'h0100})
    idle(320);
    `CHK("slew", 16'h0400, o_dac_code)
    $display("test misc done");
    give_verdict;
  end
endmodule
